// ---- pkg/dbd_pkg.sv ----
// Package for the DAC buffer and dither control block.
// Assumes a 32-bit AHB-Lite register bus and a single 125 MHz clock.
package dbd_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
  localparam logic [7:0] ADDR_EVENT_CONTROL_REGISTER    = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h10;
  localparam logic [7:0] ADDR_DATA      = 8'h14;
  localparam logic [7:0] ADDR_HOLD_BUF  = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;

  // Field positions: first control register
  localparam int FIRST_CONTROL_REGISTER_ENABLE_BIT    = 0;
  localparam int FIRST_CONTROL_REGISTER_DITHER_BIT    = 1;
  // Field positions: second control register
  localparam int SECOND_CONTROL_REGISTER_LEFT_BIT      = 0;
  localparam int SECOND_CONTROL_REGISTER_INTERNAL_OUTPUT_ENABLE_BIT      = 1;
  localparam int SECOND_CONTROL_REGISTER_PUMP_DIS_BIT  = 2;
  localparam int SECOND_CONTROL_REGISTER_EXTOUT_BIT    = 3;
  // Field positions: event control register
  localparam int EV_START_IN_BIT     = 0;
  localparam int EV_EMPTY_OUT_BIT    = 1;
  // Field positions: interrupt status and mask
  localparam int INT_UNDERRUN_BIT    = 0;
  localparam int INT_EMPTY_BIT       = 1;
  // Field positions: status register
  localparam int STAT_BUF_FULL_BIT   = 0;
  localparam int STAT_SYNC_BUSY_BIT  = 1;

  // Reset values
  localparam logic [1:0]  FIRST_CONTROL_REGISTER_RESET   = 2'h0;
  localparam logic [3:0]  SECOND_CONTROL_REGISTER_RESET   = 4'h0;
  localparam logic [1:0]  EVENT_CONTROL_REGISTER_RESET  = 2'h0;
  localparam logic [1:0]  INT_RESET     = 2'h0;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  // Dither sizing
  localparam int SUBCONV_COUNT = 16;
  localparam int CODE_WIDTH    = 10;

  // Write-synchronisation latency toward the converter side
  localparam int SYNC_CYCLES   = 2;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : dbd_pkg

// ---- pkg/dbd_dither_if.sv ----
// Interface between the control core and the dither sequencer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface dbd_dither_if;
  logic        load;      // Pulse: new sample in conversion word
  logic        step;      // Pulse: one sub-conversion event
  logic [15:0] sample;    // Conversion word
  logic        dither;    // Dithering mode
  logic        left;      // Left-justified layout
  logic [9:0]  code;      // Code presented to the converter
  logic        last;      // Pulse: sixteenth sub-conversion done, or each load without dither

  modport ctrl (output load, output step, output sample, output dither,
                output left, input code, input last);
  modport seq  (input load, input step, input sample, input dither,
                input left, output code, output last);
endinterface : dbd_dither_if

// ---- core/dbd_dither_seq.sv ----
// Dither sequencer: turns a sample into the code for each sub-conversion.
// Assumes step pulses arrive only after a load.
`timescale 1ns/10ps
module dbd_dither_seq (
  input  wire logic   clock_i,
  input  wire logic   rstn_i,
  dbd_dither_if.seq   dif
);

  typedef struct packed {
    logic [3:0] phase;
    logic [9:0] code;
    logic       last;
  } dbd_seq_state_t;

  dbd_seq_state_t st;
  dbd_seq_state_t next_st;
  logic [9:0]     base;
  logic [3:0]     frac;
  logic [3:0]     ph_use;

  // Select code and dither bits per layout
  always_comb begin
    base = dif.left ? dif.sample[15:6] : dif.sample[13:4];   // [R8] [R12]
    frac = dif.left ? dif.sample[5:2]  : dif.sample[3:0];    // [R8] [R12]
  end

  // Phase i uses code+1 while i < frac, so frac of 16 steps are bumped
  always_comb begin
    next_st      = st;
    next_st.last = 1'b0;
    ph_use       = dif.load ? 4'h0 : st.phase;
    if (dif.load || dif.step) begin
      if (dif.dither && (ph_use < frac)) begin
        next_st.code = base + 10'h001;                        // [R9] [R16]
      end else begin
        next_st.code = base;                                  // [R9]
      end
      if (dif.dither) begin
        next_st.phase = ph_use + 4'h1;
        next_st.last  = (ph_use == 4'hf);                     // [R11]
      end else begin
        next_st.phase = 4'h0;
        next_st.last  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dif.code = st.code;
  assign dif.last = st.last;

endmodule : dbd_dither_seq

// ---- core/dbd_ctrl.sv ----
// DAC control core: AHB-Lite registers, two-stage sample queue, events,
// interrupts, DMA request and converter-side static controls.
// Assumes one 125 MHz clock; the start event is a one-cycle pulse.
//
// Contract
// (R1) Holding buffer and data word form queue
// (R2) Start event moves buffer into data word
// (R3) Start events honoured only when enabled
// (R4) Start with empty buffer flags underrun
// (R5) Empty event when holding buffer empties
// (R6) Empty event output only when enabled
// (R7) Buffer empty raises its interrupt flag
// (R8) Dither: bits 13:4 code, 3:0 dither
// (R9) Sixteen sub-conversions of code or code+1
// (R10) Source gives sixteen starts per sample
// (R11) Dither: empty and DMA once per sixteen
// (R12) Left justify: code 15:6, dither 5:2
// (R13) Internal output enable feeds the comparator
// (R14) Pump disable bit turns pump off
// (R15) Enable, data, buffer writes are synchronised; buffer writes land in hold directly
// (R16) Bumped steps equal the dither value
// (R17) DMA request on empty, cleared by write
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module dbd_ctrl (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        start_event_i,
  input  wire logic        pump_auto_i,
  output logic             empty_event_o,
  output logic             dma_req_o,
  output logic             irq_o,
  output logic      [9:0]  dac_code_o,
  output logic             dac_enable_o,
  output logic             ext_output_enable_o,
  output logic             internal_output_enable_o,
  output logic             pump_on_o
);

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [1:0]  ctrl_a;
    logic [3:0]  ctrl_b;
    logic [1:0]  event_control_register;
    logic [1:0]  int_mask;
    logic [1:0]  int_stat;
    logic [15:0] data;
    logic [15:0] hold;
    logic        hold_full;
    logic [1:0]  sync_en;
    logic [1:0]  sync_dat;
    logic        dat_new;
    logic        load;
    logic        step;
    logic        empty_ev;
    logic        dma_req;
    logic        irq;
    logic [31:0] rdata;
    logic [9:0]  code;
    logic        ext_oe;
    logic        int_oe;
    logic        pump_on;
  } dbd_ctrl_state_t;

  dbd_ctrl_state_t st;
  dbd_ctrl_state_t next_st;
  dbd_dither_if    dif ();

  logic addr_take;
  logic wr_data;
  logic wr_hold;
  logic start_ok;
  logic dither;
  logic empties;
  logic [1:0] ev_set;
  logic [1:0] w1c;

  dbd_dither_seq u_seq (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .dif     (dif)
  );

  // Queue control to the sequencer
  assign dif.load   = st.load;
  assign dif.step   = st.step;
  assign dif.sample = st.data;
  assign dif.dither = st.ctrl_a[dbd_pkg::FIRST_CONTROL_REGISTER_DITHER_BIT];
  assign dif.left   = st.ctrl_b[dbd_pkg::SECOND_CONTROL_REGISTER_LEFT_BIT];

  // Decode an address phase; the write lands in the following data phase
  always_comb begin
    addr_take = hsel_i && hready_i && htrans_i[1];
    wr_data   = st.wr_pend && (st.wr_addr == dbd_pkg::ADDR_DATA);
    wr_hold   = st.wr_pend && (st.wr_addr == dbd_pkg::ADDR_HOLD_BUF);
    dither    = st.ctrl_a[dbd_pkg::FIRST_CONTROL_REGISTER_DITHER_BIT];
    // Starts only once enable has reached the converter side
    start_ok  = start_event_i && st.sync_en[1]
              && st.event_control_register[dbd_pkg::EV_START_IN_BIT];          // [R3] [R15]
    w1c       = (st.wr_pend && (st.wr_addr == dbd_pkg::ADDR_INT_STAT))
              ? hwdata_i[1:0] : 2'h0;
  end

  always_comb begin
    next_st          = st;
    next_st.load     = 1'b0;
    next_st.step     = 1'b0;
    next_st.empty_ev = 1'b0;
    empties          = 1'b0;
    ev_set           = 2'h0;

    // Register writes
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        dbd_pkg::ADDR_CTRL_A:   next_st.ctrl_a   = hwdata_i[1:0];
        dbd_pkg::ADDR_CTRL_B:   next_st.ctrl_b   = hwdata_i[3:0];
        dbd_pkg::ADDR_EVENT_CONTROL_REGISTER:   next_st.event_control_register   = hwdata_i[1:0];
        dbd_pkg::ADDR_INT_MASK: next_st.int_mask = hwdata_i[1:0];
        default: ;
      endcase
    end

    // Enable passes a two-stage synchroniser
    next_st.sync_en = {st.sync_en[0],
                       st.ctrl_a[dbd_pkg::FIRST_CONTROL_REGISTER_ENABLE_BIT]};   // [R15]
    next_st.sync_dat = {st.sync_dat[0], wr_data};               // [R15]

    // Direct data write: reload the converter once it is synchronised
    if (wr_data) begin
      next_st.data = hwdata_i[15:0];
    end
    if (st.sync_dat[1]) begin
      next_st.load = 1'b1;
    end

    // Start event: step the dither, advance queue or flag underrun
    if (start_ok) begin
      if (dither && !dif.last && !st.load && !st.sync_dat[1]
          && st.dat_new) begin
        next_st.step = 1'b1;                                    // [R9]
      end else if (st.hold_full) begin
        next_st.data      = st.hold;                            // [R1] [R2]
        next_st.hold_full = 1'b0;
        next_st.load      = 1'b1;                               // [R2]
        next_st.dat_new   = 1'b1;
        empties           = 1'b1;
      end else begin
        ev_set[dbd_pkg::INT_UNDERRUN_BIT] = 1'b1;               // [R4]
      end
    end
    // Last of sixteen sub-conversions frees the word for a new sample
    if (dither && dif.last && !next_st.load) begin
      next_st.dat_new = 1'b0;                                   // [R11]
    end
    if (!dither) begin
      next_st.dat_new = 1'b0;
    end

    // Buffer write fills the holding stage
    if (wr_hold) begin
      next_st.hold      = hwdata_i[15:0];                       // [R1]
      next_st.hold_full = 1'b1;
      next_st.dma_req   = 1'b0;                                 // [R17]
    end

    // Emptying gives event, interrupt and DMA request
    if (empties) begin
      next_st.empty_ev = st.event_control_register[dbd_pkg::EV_EMPTY_OUT_BIT];  // [R5] [R6]
      next_st.dma_req  = 1'b1;                                  // [R17] [R11]
      ev_set[dbd_pkg::INT_EMPTY_BIT] = 1'b1;                    // [R7]
    end

    // Sticky flags: a set in the same cycle beats the write-one clear
    next_st.int_stat = (st.int_stat & ~w1c) | ev_set;
    next_st.irq      = |(next_st.int_stat & next_st.int_mask);

    // Register reads are taken straight, no synchronisation needed
    next_st.wr_pend = addr_take && hwrite_i;
    if (addr_take) begin
      next_st.wr_addr = haddr_i;
    end
    if (addr_take && !hwrite_i) begin
      unique case (haddr_i)
        dbd_pkg::ADDR_CTRL_A:   next_st.rdata = {30'h0, st.ctrl_a};
        dbd_pkg::ADDR_CTRL_B:   next_st.rdata = {28'h0, st.ctrl_b};
        dbd_pkg::ADDR_EVENT_CONTROL_REGISTER:   next_st.rdata = {30'h0, st.event_control_register};
        dbd_pkg::ADDR_INT_MASK: next_st.rdata = {30'h0, st.int_mask};
        dbd_pkg::ADDR_INT_STAT: next_st.rdata = {30'h0, st.int_stat};
        dbd_pkg::ADDR_DATA:     next_st.rdata = {16'h0, st.data};
        dbd_pkg::ADDR_HOLD_BUF: next_st.rdata = {16'h0, st.hold};
        dbd_pkg::ADDR_STATUS:   next_st.rdata = {30'h0,
                                  (st.sync_dat != 2'h0) ||
                                  (st.sync_en[1] !=
                                   st.ctrl_a[dbd_pkg::FIRST_CONTROL_REGISTER_ENABLE_BIT]),
                                  st.hold_full};
        default:                next_st.rdata = 32'h0;
      endcase
    end

    // Converter-side static controls
    next_st.code    = dif.code;
    next_st.ext_oe  = st.sync_en[1]
                    && st.ctrl_b[dbd_pkg::SECOND_CONTROL_REGISTER_EXTOUT_BIT];
    next_st.int_oe  = st.sync_en[1]
                    && st.ctrl_b[dbd_pkg::SECOND_CONTROL_REGISTER_INTERNAL_OUTPUT_ENABLE_BIT];      // [R13]
    next_st.pump_on = pump_auto_i
                    && !st.ctrl_b[dbd_pkg::SECOND_CONTROL_REGISTER_PUMP_DIS_BIT]; // [R14]
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st          <= '0;
      st.ctrl_a   <= dbd_pkg::FIRST_CONTROL_REGISTER_RESET;
      st.ctrl_b   <= dbd_pkg::SECOND_CONTROL_REGISTER_RESET;
      st.event_control_register   <= dbd_pkg::EVENT_CONTROL_REGISTER_RESET;
      st.int_mask <= dbd_pkg::INT_RESET;
      st.int_stat <= dbd_pkg::INT_RESET;
      st.data     <= dbd_pkg::DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // All outputs but hreadyout_o and hresp_o straight from state flops; the slave never waits
  assign hrdata_o                 = st.rdata;
  assign hreadyout_o              = 1'b1;
  assign hresp_o                  = 1'b0;
  assign empty_event_o            = st.empty_ev;
  assign dma_req_o                = st.dma_req;
  assign irq_o                    = st.irq;
  assign dac_code_o               = st.code;
  assign dac_enable_o             = st.sync_en[1];
  assign ext_output_enable_o      = st.ext_oe;
  assign internal_output_enable_o = st.int_oe;
  assign pump_on_o                = st.pump_on;

endmodule : dbd_ctrl

// ---- testbench/dbd_evsrc.sv ----
// Event source model: bursts of one-cycle start-conversion pulses.
// Assumes one shared clock; a burst is requested by a one-cycle go_i.
`timescale 1ns/10ps
module dbd_evsrc (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire logic [4:0] count_i,
  input  wire logic [3:0] gap_i,
  output logic            start_o,
  output logic            busy_o
);
  logic [4:0] left_q;
  logic [3:0] wait_q;

  // Gap of three or more idle cycles keeps sub-conversions apart
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_q  <= 5'h00;
      wait_q  <= 4'h0;
      start_o <= 1'b0;
    end else begin
      start_o <= 1'b0;
      if (go_i) begin
        left_q <= count_i; // Sixteen pulses per dithered sample
        wait_q <= gap_i;
      end else if (left_q != 5'h00 && wait_q == 4'h0) begin
        start_o <= 1'b1;
        left_q  <= left_q - 5'h01;
        wait_q  <= gap_i;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end

  assign busy_o = (left_q != 5'h00) || start_o;
endmodule : dbd_evsrc

// ---- testbench/dbd_ctrl_chk.sv ----
// Checker on the DAC control core ports: bus, events, DMA and pump.
// Assumes one clock domain; bound to every instance of the core.
`timescale 1ns/10ps
module dbd_ctrl_chk (
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       start_event_i,
  input wire logic       pump_auto_i,
  input wire logic       empty_event_o,
  input wire logic       dma_req_o,
  input wire logic       dac_enable_o,
  input wire logic       pump_on_o
);
  logic hold_wr;

  // Address phase of a holding buffer write
  assign hold_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i &&
                   haddr_i == dbd_pkg::ADDR_HOLD_BUF;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_bus_ready: assert property (hreadyout_o)
    else $error("slave not ready");
  a_bus_okay: assert property (!hresp_o)
    else $error("error response");
  a_start_gated: assert property (
    start_event_i && !dac_enable_o |=> !empty_event_o)
    else $error("start taken while disabled");
  a_empty_pulse: assert property (empty_event_o |=> !empty_event_o)
    else $error("empty event longer than a cycle");
  a_empty_cause: assert property (
    empty_event_o |-> $past(start_event_i) && $past(dac_enable_o))
    else $error("empty event without a start");
  a_empty_dma: assert property (empty_event_o |-> dma_req_o)
    else $error("empty event without dma request");
  a_dma_rise: assert property ($rose(dma_req_o) |-> $past(start_event_i))
    else $error("dma request without a start");
  a_dma_clear: assert property ($fell(dma_req_o) |-> $past(hold_wr, 2))
    else $error("dma request dropped without a buffer write");
  a_pump_follow: assert property (!pump_auto_i |=> !pump_on_o)
    else $error("pump on while not wanted");
endmodule : dbd_ctrl_chk

bind dbd_ctrl dbd_ctrl_chk u_dbd_ctrl_chk (.*);

// ---- testbench/dbd_ctrl_tb.sv ----
// Testbench for the DAC control core: bus, queue, events, dither.
// Assumes the core is the only AHB-Lite slave; hready is its hreadyout.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module dbd_ctrl_tb;
  logic        clock_i = 1'b0, rstn_i = 1'b0, pump = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [2:0]  hsize = 3'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd, hrdata;
  logic [4:0]  cnt = 5'h01;
  logic [3:0]  gap = 4'h3, st_d = 4'h0;
  logic [9:0]  code, codes[$];
  logic        hready, hresp, start, busy, ev, dma, irq, en, ie;
  logic        pon, eo;
  int          n_mismatch = 0, checked = 0, n_empty = 0;
  int          seed = 32'ha4b3;

  initial forever #4 clock_i = ~clock_i;

  dbd_ctrl u_dbd_ctrl (.clock_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .start_event_i(start),
    .pump_auto_i(pump), .empty_event_o(ev), .dma_req_o(dma), .irq_o(irq),
    .dac_code_o(code), .dac_enable_o(en), .ext_output_enable_o(eo),
    .internal_output_enable_o(ie), .pump_on_o(pon));
  dbd_evsrc u_dbd_evsrc (.clock_i, .rstn_i, .go_i(go), .count_i(cnt),
    .gap_i(gap), .start_o(start), .busy_o(busy));

  // Code shown three edges after each start; counted empty events
  always @(posedge clock_i) st_d <= {st_d[2:0], start};
  always @(negedge clock_i) if (st_d[3]) codes.push_back(code);
  always @(posedge clock_i) if (ev === 1'b1) n_empty++;

  // One single transfer; held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel   <= 1'b1;
    htrans <= dbd_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= dbd_pkg::HSIZE_WORD;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask : rc

  // Burst of n starts at a random spacing, then let effects land
  task automatic fire(input logic [4:0] n);
    @(posedge clock_i);
    cnt <= n;
    gap <= 4'h3 + 4'($unsigned($random(seed)) % 6);
    go  <= 1'b1;
    @(posedge clock_i);
    go  <= 1'b0;
    do @(posedge clock_i); while (busy === 1'b1);
    repeat (5) @(posedge clock_i);
  endtask : fire

  // Code expected at sub-conversion i: bumped while i is below the dither
  function automatic logic [9:0] exp_code(input logic [15:0] s,
                                          input logic lj, input int i);
    logic [9:0] b;
    logic [3:0] f;
    b = lj ? s[15:6] : s[13:4];
    f = lj ? s[5:2] : s[3:0];
    return b + 10'(i < f);
  endfunction : exp_code

  task automatic dith(input logic lj);
    logic [15:0] s;
    s = 16'($random(seed));
    s[15] = 1'b0;
    s[13] = 1'b0;
    bus(1'b1, dbd_pkg::ADDR_CTRL_B, {30'h0, 1'b1, lj});
    bus(1'b1, dbd_pkg::ADDR_HOLD_BUF, {16'h0, s});
    codes.delete();
    n_empty = 0;
    fire(5'h10);
    `CHK("codes", 16, codes.size())
    for (int i = 0; i < 16 && i < codes.size(); i++) begin
      `CHK("code", exp_code(s, lj, i), codes[i])
    end
    `CHK("empties", 1, n_empty)
  endtask : dith

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    logic [31:0] v;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    // Reset values, and one unmapped word past the map
    for (int a = 0; a < 9; a++) rc(8'(a * 4), 32'h0);
    v = {16'h0, 16'($random(seed))};
    bus(1'b1, dbd_pkg::ADDR_INT_MASK, 32'h3);
    bus(1'b1, dbd_pkg::ADDR_HOLD_BUF, v);
    fire(5'h01);
    rc(dbd_pkg::ADDR_INT_STAT, 32'h0);
    rc(dbd_pkg::ADDR_STATUS, 32'h1);
    bus(1'b1, dbd_pkg::ADDR_CTRL_A, 32'h1);
    // Enable still crossing: sync busy shows next to the full buffer
    rc(dbd_pkg::ADDR_STATUS, 32'h3);
    bus(1'b1, dbd_pkg::ADDR_EVENT_CONTROL_REGISTER, 32'h1);
    repeat (4) @(posedge clock_i);
    `CHK("enable", 1'b1, en)
    fire(5'h01);
    `CHK("empty events", 0, n_empty)
    `CHK("dma", 1'b1, dma)
    `CHK("irq", 1'b1, irq)
    rc(dbd_pkg::ADDR_INT_STAT, 32'h2);
    rc(dbd_pkg::ADDR_DATA, v);
    // Direct data write is synchronised before it reaches the converter
    bus(1'b1, dbd_pkg::ADDR_DATA, {16'h0, ~v[15:0]});
    rc(dbd_pkg::ADDR_STATUS, 32'h2);
    rc(dbd_pkg::ADDR_DATA, {16'h0, ~v[15:0]});
    bus(1'b1, dbd_pkg::ADDR_INT_STAT, 32'h2);
    bus(1'b1, dbd_pkg::ADDR_INT_MASK, 32'h0);
    fire(5'h01);
    rc(dbd_pkg::ADDR_INT_STAT, 32'h1);
    `CHK("masked irq", 1'b0, irq)
    bus(1'b1, dbd_pkg::ADDR_INT_STAT, 32'h1);
    bus(1'b1, dbd_pkg::ADDR_INT_MASK, 32'h3);
    bus(1'b1, dbd_pkg::ADDR_HOLD_BUF, v);
    repeat (2) @(posedge clock_i);
    `CHK("dma after write", 1'b0, dma)
    bus(1'b1, dbd_pkg::ADDR_EVENT_CONTROL_REGISTER, 32'h3);
    n_empty = 0;
    fire(5'h01);
    `CHK("empty events", 1, n_empty)
    // Pump wanted, then disabled; comparator route on
    pump <= 1'b1;
    bus(1'b1, dbd_pkg::ADDR_CTRL_B, 32'h2);
    repeat (3) @(posedge clock_i);
    `CHK("pump on", 1'b1, pon)
    `CHK("internal out", 1'b1, ie)
    `CHK("external out", 1'b0, eo)
    bus(1'b1, dbd_pkg::ADDR_CTRL_B, 32'he);
    repeat (3) @(posedge clock_i);
    `CHK("pump off", 1'b0, pon)
    `CHK("both outputs", 2'h3, {eo, ie})
    bus(1'b1, dbd_pkg::ADDR_CTRL_A, 32'h3);
    repeat (4) @(posedge clock_i);
    dith(1'b0);
    dith(1'b1);
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    print_verdict();
  end
endmodule : dbd_ctrl_tb
